//--- design/text_page_pkg.sv
// Constants and types shared by the text page arbiter
package text_page_pkg;
    // -------------------------------------------------------------------------
    // Page set and fields
    // -------------------------------------------------------------------------
    localparam int          N_PAGES   = 32;
    localparam int          IDX_W     = 5;
    localparam int          PRIO_W    = 6;
    localparam int          ROLL_W    = 5;
    localparam int          KEY_N     = 4;
    localparam logic [5:0]  PRIO_MAX  = 6'h20;
    localparam logic [IDX_W-1:0] IDX_LAST = 5'h1f;
    // -------------------------------------------------------------------------
    // Character grid
    // -------------------------------------------------------------------------
    localparam int          PAGE_LINES = 6;
    localparam int          PAGE_COLS  = 16;
    localparam int          PAGE_CELLS = PAGE_LINES * PAGE_COLS;
    localparam int          CELL_W     = 12;
    // -------------------------------------------------------------------------
    // Language table
    // -------------------------------------------------------------------------
    localparam int          LANG_N = 4;
    localparam int          LANG_W = 2;
    localparam int          SEL_W  = 8;
    // -------------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          SEC_NS        = 1_000_000_000;
    localparam int          SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
    localparam int          TICK_W        = 24;
    // -------------------------------------------------------------------------
    // Reset values and encodings
    // -------------------------------------------------------------------------
    localparam logic [TICK_W-1:0] TICK_RST = 24'h0;
    localparam logic [ROLL_W-1:0] ROLL_RST = 5'h0;
    localparam logic [ROLL_W-1:0] ROLL_SAT = 5'h1f;
    localparam logic [IDX_W:0]    CNT_RST  = 6'h0;

    typedef enum logic [1:0] {
        COL_WHITE = 2'h0,
        COL_GREEN = 2'h1,
        COL_RED   = 2'h2
    } colour_t;

    typedef enum logic [1:0] {
        MODE_IDLE   = 2'h0,
        MODE_NORMAL = 2'h1,
        MODE_ALARM  = 2'h3
    } mode_t;
endpackage

//--- design/alarm_order_mem.sv
// Small memory holding alarm page indices in enable order
module alarm_order_mem
    import text_page_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             wr_en,
    input  wire logic [IDX_W-1:0] wr_addr,
    input  wire logic [IDX_W-1:0] wr_data,
    input  wire logic [IDX_W-1:0] rd_addr,
    output logic      [IDX_W-1:0] rd_data_ff
);
    logic [IDX_W-1:0] mem [N_PAGES];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Bypass so a word written to the read address shows at once
    always_ff @(posedge core_clk) begin
        if (wr_en && wr_addr == rd_addr) begin
            rd_data_ff <= wr_data;
        end else begin
            rd_data_ff <= mem[rd_addr];
        end
    end
endmodule

//--- design/text_page_priority_arbiter.sv
// Selects the visible text page by alarm order, priority and rolling time
//
// Function
// - page priority 1..32, 1 most important
// - top enabled page stays while enabled
// - lower page waits for higher pages off
// - equal top priorities rotate by rolling time
// - rolling time whole seconds, 1 to 31
// - enabled alarm page pre-empts at once
// - alarm page held until rising acknowledge
// - several alarms shown in enable order
// - after all alarms, normal arbitration resumes
// - acknowledge counts only for visible page
// - each page has own key mask
// - page keys need global key enable
// - backlight colour white, green or red
// - element colour overrides page default colour
// - page is 6 lines of 16 cells
// - unmatched selector falls back to default
// - only one page visible at once
// - status output mirrors enable input
// - acknowledge pulse only while page visible
module text_page_priority_arbiter
    import text_page_pkg::*;
#(
    parameter int SEC_CYC = SEC_CYCLES
) (
    input  wire logic                      core_clk,
    input  wire logic                      srst,
    input  wire logic [N_PAGES-1:0]        page_en,
    input  wire logic [N_PAGES-1:0]        alarm_ack_in,
    input  wire logic [N_PAGES*PRIO_W-1:0] page_prio_flat,
    input  wire logic [N_PAGES*ROLL_W-1:0] page_roll_flat,
    input  wire logic [N_PAGES-1:0]        page_alarm,
    input  wire logic [N_PAGES*KEY_N-1:0]  page_key_mask_flat,
    input  wire logic                      key_global_en,
    input  wire logic [N_PAGES*2-1:0]      page_colour_flat,
    input  wire logic                      elem_colour_valid,
    input  wire logic [1:0]                elem_colour,
    input  wire logic                      lang_sel_en,
    input  wire logic [SEL_W-1:0]          byte_marker_selector,
    input  wire logic [LANG_N*SEL_W-1:0]   lang_value_flat,
    input  wire logic [LANG_W-1:0]         lang_default_idx,
    output logic      [N_PAGES-1:0]        page_status_out,
    output logic      [N_PAGES-1:0]        alarm_ack_pulse_out,
    output logic                           page_visible,
    output logic      [IDX_W-1:0]          page_index,
    output logic      [CELL_W-1:0]         cell_base,
    output logic      [KEY_N-1:0]          key_active,
    output logic      [1:0]                backlight_output,
    output logic      [LANG_W-1:0]         lang_index
);
    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    // First set bit after cur, wrapping; cur itself is checked last
    function automatic logic [IDX_W-1:0] rr_next(input logic [N_PAGES-1:0] set,
                                                 input logic [IDX_W-1:0]   cur);
        logic [IDX_W-1:0] idx;
        logic             found;
        rr_next = cur;
        found   = 1'b0;
        for (int k = 1; k <= N_PAGES; k++) begin
            idx = IDX_W'(int'(cur) + k);
            if (!found && set[idx]) begin
                rr_next = idx;
                found   = 1'b1;
            end
        end
    endfunction

    // -------------------------------------------------------------------------
    // Input synchronisers and edges
    // -------------------------------------------------------------------------
    logic [N_PAGES-1:0] en_meta_ff, en_s_ff, en_prev_ff;
    logic [N_PAGES-1:0] ack_meta_ff, ack_s_ff, ack_prev_ff;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            en_meta_ff  <= '0;
            en_s_ff     <= '0;
            en_prev_ff  <= '0;
            ack_meta_ff <= '0;
            ack_s_ff    <= '0;
            ack_prev_ff <= '0;
        end else begin
            en_meta_ff  <= page_en;
            en_s_ff     <= en_meta_ff;
            en_prev_ff  <= en_s_ff;
            ack_meta_ff <= alarm_ack_in;
            ack_s_ff    <= ack_meta_ff;
            ack_prev_ff <= ack_s_ff;
        end
    end

    wire [N_PAGES-1:0] en_rise  = en_s_ff & ~en_prev_ff;
    wire [N_PAGES-1:0] ack_rise = ack_s_ff & ~ack_prev_ff;

    assign page_status_out = en_s_ff;

    // -------------------------------------------------------------------------
    // Per-page fields
    // -------------------------------------------------------------------------
    logic [PRIO_W-1:0] prio [N_PAGES];
    logic [ROLL_W-1:0] roll [N_PAGES];
    logic [KEY_N-1:0]  keys [N_PAGES];
    logic [1:0]        colr [N_PAGES];

    for (genvar g = 0; g < N_PAGES; g++) begin : g_fields
        assign prio[g] = page_prio_flat[g*PRIO_W +: PRIO_W];
        assign roll[g] = page_roll_flat[g*ROLL_W +: ROLL_W];
        assign keys[g] = page_key_mask_flat[g*KEY_N +: KEY_N];
        assign colr[g] = page_colour_flat[g*2 +: 2];
    end

    // -------------------------------------------------------------------------
    // Alarm order queue
    // -------------------------------------------------------------------------
    mode_t              mode_ff, nxt_mode;
    logic [IDX_W-1:0]   vis_idx_ff, nxt_idx;
    logic [N_PAGES-1:0] req_ff, pending_ff;
    logic [IDX_W-1:0]   wr_ptr_ff, rd_ptr_ff;
    logic [IDX_W:0]     count_ff;
    logic [IDX_W-1:0]   head;

    wire                push     = |req_ff;
    wire  [IDX_W-1:0]   push_idx = rr_next(req_ff, IDX_LAST);
    wire  [N_PAGES-1:0] push_oh  = push ? (N_PAGES'(1) << push_idx) : '0;
    wire                ack_hit  = (mode_ff == MODE_ALARM) && ack_rise[vis_idx_ff];
    wire  [N_PAGES-1:0] pop_oh   = ack_hit ? (N_PAGES'(1) << vis_idx_ff) : '0;
    wire                head_ok  = count_ff != CNT_RST;
    wire  [IDX_W-1:0]   nxt_rd   = ack_hit ? IDX_W'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
    wire  [N_PAGES-1:0] new_alarm = en_rise & page_alarm & ~pending_ff;

    alarm_order_mem u_order (
        .core_clk   (core_clk),
        .wr_en      (push),
        .wr_addr    (wr_ptr_ff),
        .wr_data    (push_idx),
        .rd_addr    (nxt_rd),
        .rd_data_ff (head)
    );

    always_ff @(posedge core_clk) begin
        if (srst) begin
            req_ff     <= '0;
            pending_ff <= '0;
            wr_ptr_ff  <= '0;
            rd_ptr_ff  <= '0;
            count_ff   <= CNT_RST;
        end else begin
            req_ff     <= (req_ff & ~push_oh) | new_alarm;
            pending_ff <= (pending_ff & ~pop_oh) | push_oh;
            wr_ptr_ff  <= push ? IDX_W'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
            rd_ptr_ff  <= nxt_rd;
            count_ff   <= count_ff + {5'h0, push} - {5'h0, ack_hit};
        end
    end

    // -------------------------------------------------------------------------
    // Priority and rotation
    // -------------------------------------------------------------------------
    logic [PRIO_W-1:0]  min_prio;
    logic [N_PAGES-1:0] top_set;
    logic [ROLL_W-1:0]  roll_sec_ff;
    logic [TICK_W-1:0]  tick_cnt_ff;

    wire [N_PAGES-1:0] eligible = en_s_ff & ~page_alarm;

    always_comb begin
        min_prio = PRIO_MAX;
        for (int i = 0; i < N_PAGES; i++) begin
            if (eligible[i] && prio[i] < min_prio) begin
                min_prio = prio[i];
            end
        end
    end

    for (genvar g = 0; g < N_PAGES; g++) begin : g_top
        assign top_set[g] = eligible[g] && prio[g] == min_prio;
    end

    wire cur_in_top = (mode_ff == MODE_NORMAL) && top_set[vis_idx_ff];
    wire sec_tick   = tick_cnt_ff == TICK_W'(SEC_CYC - 1);
    // Look ahead one cycle so a page shows exactly its rolling time
    wire roll_last  = sec_tick && ROLL_W'(roll_sec_ff + 1'b1) >= roll[vis_idx_ff];
    wire roll_done  = (roll_sec_ff >= roll[vis_idx_ff]) || roll_last;
    wire [IDX_W-1:0] norm_idx = (cur_in_top && !roll_done) ? vis_idx_ff
                                                           : rr_next(top_set, vis_idx_ff);

    always_comb begin
        if (head_ok) begin
            nxt_mode = MODE_ALARM;
        end else if (|top_set) begin
            nxt_mode = MODE_NORMAL;
        end else begin
            nxt_mode = MODE_IDLE;
        end
        case (nxt_mode)
            MODE_ALARM:  nxt_idx = head;
            MODE_NORMAL: nxt_idx = norm_idx;
            default:     nxt_idx = '0;
        endcase
    end

    wire changed  = (nxt_mode != mode_ff) || (nxt_idx != vis_idx_ff);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            mode_ff    <= MODE_IDLE;
            vis_idx_ff <= '0;
        end else begin
            mode_ff    <= nxt_mode;
            vis_idx_ff <= nxt_idx;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst || changed) begin
            tick_cnt_ff <= TICK_RST;
            roll_sec_ff <= ROLL_RST;
        end else if (sec_tick) begin
            tick_cnt_ff <= TICK_RST;
            roll_sec_ff <= (roll_sec_ff == ROLL_SAT) ? roll_sec_ff
                                                     : ROLL_W'(roll_sec_ff + 1'b1);
        end else begin
            tick_cnt_ff <= TICK_W'(tick_cnt_ff + 1'b1);
        end
    end

    // -------------------------------------------------------------------------
    // Page attributes and language
    // -------------------------------------------------------------------------
    logic [LANG_W-1:0] lang_pick;

    always_comb begin
        lang_pick = lang_default_idx;
        for (int j = LANG_N - 1; j >= 0; j--) begin
            if (lang_sel_en && lang_value_flat[j*SEL_W +: SEL_W] == byte_marker_selector) begin
                lang_pick = LANG_W'(j);
            end
        end
    end

    wire [1:0] page_col = (colr[nxt_idx] == 2'h3) ? COL_WHITE : colr[nxt_idx];
    wire [1:0] el_col   = (elem_colour == 2'h3) ? COL_WHITE : elem_colour;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            alarm_ack_pulse_out <= '0;
            cell_base           <= '0;
            key_active          <= '0;
            backlight_output    <= COL_WHITE;
            lang_index          <= '0;
        end else begin
            alarm_ack_pulse_out <= pop_oh;
            cell_base           <= CELL_W'(int'(nxt_idx) * PAGE_CELLS);
            key_active          <= (key_global_en && nxt_mode != MODE_IDLE)
                                   ? keys[nxt_idx] : '0;
            backlight_output    <= elem_colour_valid ? el_col : page_col;
            lang_index          <= lang_pick;
        end
    end

    assign page_visible = mode_ff != MODE_IDLE;
    assign page_index   = vis_idx_ff;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    sequence s_alarm_shown;
        mode_ff == MODE_ALARM && pending_ff[vis_idx_ff] && !ack_hit;
    endsequence

    sequence s_alarm_stays;
        mode_ff == MODE_ALARM && vis_idx_ff == $past(vis_idx_ff);
    endsequence

    property p_alarm_hold;
        @(posedge core_clk) disable iff (srst) s_alarm_shown |=> s_alarm_stays;
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm page left unacked");

    property p_alarm_preempt;
        @(posedge core_clk) disable iff (srst) head_ok |=> page_visible && page_index == $past(head);
    endproperty
    a_alarm_preempt: assert property (p_alarm_preempt) else $error("queued alarm not shown");

    property p_idle_none;
        @(posedge core_clk) disable iff (srst)
            (!head_ok && !(|eligible)) |=> !page_visible && page_index == '0;
    endproperty
    a_idle_none: assert property (p_idle_none) else $error("page shown with none enabled");

    property p_status_mirror;
        @(posedge core_clk) disable iff (srst)
            !$past(srst) && !$past(srst, 2) |-> page_status_out == $past(page_en, 2);
    endproperty
    a_status_mirror: assert property (p_status_mirror) else $error("status differs from enable");

    property p_ack_visible;
        @(posedge core_clk) disable iff (srst)
            |alarm_ack_pulse_out |-> $past(mode_ff) == MODE_ALARM
                && alarm_ack_pulse_out == (N_PAGES'(1) << $past(vis_idx_ff));
    endproperty
    a_ack_visible: assert property (p_ack_visible) else $error("ack pulse for hidden page");

    property p_top_only;
        @(posedge core_clk) disable iff (srst)
            (!head_ok && |top_set) |=> mode_ff == MODE_NORMAL && $past(top_set[nxt_idx]);
    endproperty
    a_top_only: assert property (p_top_only) else $error("lower priority page shown");

    property p_hold_top;
        @(posedge core_clk) disable iff (srst)
            (!head_ok && cur_in_top && top_set == (N_PAGES'(1) << vis_idx_ff))
                |=> page_index == $past(page_index);
    endproperty
    a_hold_top: assert property (p_hold_top) else $error("single top page not held");

    property p_roll_restart;
        @(posedge core_clk) disable iff (srst)
            changed |=> roll_sec_ff == ROLL_RST && tick_cnt_ff == TICK_RST;
    endproperty
    a_roll_restart: assert property (p_roll_restart) else $error("roll counter not restarted");

    property p_key_gate;
        @(posedge core_clk) disable iff (srst) !key_global_en |=> key_active == '0;
    endproperty
    a_key_gate: assert property (p_key_gate) else $error("keys active without global enable");

    property p_lang_default;
        @(posedge core_clk) disable iff (srst)
            !lang_sel_en |=> lang_index == $past(lang_default_idx);
    endproperty
    a_lang_default: assert property (p_lang_default) else $error("language not default");
endmodule

//--- dv/page_program_model.sv
// Program-side model driving page enables and acknowledges
module page_program_model
    import text_page_pkg::*;
(
    input  wire logic               core_clk,
    output logic      [N_PAGES-1:0] page_en,
    output logic      [N_PAGES-1:0] alarm_ack_in
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        page_en      = '0;
        alarm_ack_in = '0;
    end

    // Changes land just after a rising edge
    task automatic set_en(input logic [N_PAGES-1:0] m, input logic v);
        @(posedge core_clk);
        #2;
        page_en = v ? (page_en | m) : (page_en & ~m);
    endtask

    // Clearing needs a fresh low-to-high step, a held level is not a new edge
    task automatic set_ack(input logic [N_PAGES-1:0] m, input logic v);
        @(posedge core_clk);
        #2;
        alarm_ack_in = v ? (alarm_ack_in | m) : (alarm_ack_in & ~m);
    endtask
endmodule

//--- dv/text_page_priority_arbiter_test.sv
// Self-checking bench for the text page arbiter
module text_page_priority_arbiter_test
    import text_page_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // -------------------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------------------
    localparam int SEC_T = 10;
    typedef struct packed {logic vis; logic [IDX_W-1:0] idx; int gap;} note_t;

    logic                      core_clk, srst, key_global_en, elem_colour_valid, lang_sel_en;
    logic [N_PAGES-1:0]        page_en, alarm_ack_in, page_alarm;
    logic [N_PAGES*PRIO_W-1:0] page_prio_flat;
    logic [N_PAGES*ROLL_W-1:0] page_roll_flat;
    logic [N_PAGES*KEY_N-1:0]  page_key_mask_flat;
    logic [N_PAGES*2-1:0]      page_colour_flat;
    logic [1:0]                elem_colour, backlight_output, ec;
    logic [SEL_W-1:0]          byte_marker_selector;
    logic [LANG_N*SEL_W-1:0]   lang_value_flat;
    logic [LANG_W-1:0]         lang_default_idx, lang_index, exp_lang;
    logic [N_PAGES-1:0]        page_status_out, alarm_ack_pulse_out, pulses, en_h1, en_h2;
    logic                      page_visible;
    logic [IDX_W-1:0]          page_index;
    logic [CELL_W-1:0]         cell_base;
    logic [KEY_N-1:0]          key_active;
    logic [5:0]                last_seen;
    logic [31:0]               xs_state;
    note_t                     notes[$];
    note_t                     nt;
    int                        n_fail, compares, cyc_cnt;

    page_program_model u_prog (.core_clk(core_clk), .page_en(page_en),
                               .alarm_ack_in(alarm_ack_in));

    text_page_priority_arbiter #(.SEC_CYC(SEC_T)) u_dut (
        .core_clk(core_clk), .srst(srst), .page_en(page_en), .alarm_ack_in(alarm_ack_in),
        .page_prio_flat(page_prio_flat), .page_roll_flat(page_roll_flat),
        .page_alarm(page_alarm), .page_key_mask_flat(page_key_mask_flat),
        .key_global_en(key_global_en), .page_colour_flat(page_colour_flat),
        .elem_colour_valid(elem_colour_valid), .elem_colour(elem_colour),
        .lang_sel_en(lang_sel_en), .byte_marker_selector(byte_marker_selector),
        .lang_value_flat(lang_value_flat), .lang_default_idx(lang_default_idx),
        .page_status_out(page_status_out), .alarm_ack_pulse_out(alarm_ack_pulse_out),
        .page_visible(page_visible), .page_index(page_index), .cell_base(cell_base),
        .key_active(key_active), .backlight_output(backlight_output),
        .lang_index(lang_index));

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs();
        xs_state = xs_state ^ (xs_state << 13);
        xs_state = xs_state ^ (xs_state >> 17);
        xs_state = xs_state ^ (xs_state << 5);
        return xs_state;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic note(input logic v, input logic [IDX_W-1:0] i, input int gap);
        notes.push_back('{v, i, gap});
    endtask

    task automatic drain();
        for (int k = 0; k < 300 && notes.size() != 0; k++) @(posedge core_clk);
        check(notes.size(), 0);
        repeat (2) @(posedge core_clk);
        #2;
    endtask

    task automatic results();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // -------------------------------------------------------------------------
    // Monitor: visible page changes, status mirror, pulses
    // -------------------------------------------------------------------------
    always @(negedge core_clk) begin
        cyc_cnt++;
        pulses = pulses | alarm_ack_pulse_out;
        if (!srst) check(page_status_out, en_h2);
        en_h2 = en_h1;
        en_h1 = page_en;
        if ({page_visible, page_index} !== last_seen) begin
            if (notes.size() == 0) begin
                check({page_visible, page_index}, last_seen);
            end else begin
                nt = notes.pop_front();
                check({page_visible, page_index}, {nt.vis, nt.idx});
                if (nt.gap != 0) check(cyc_cnt, nt.gap);
            end
            last_seen = {page_visible, page_index};
            cyc_cnt = 0;
        end
    end

    initial begin
        #(100 * 20000);
        n_fail++;
        results();
    end

    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial begin
        {n_fail, compares, cyc_cnt} = '0;
        xs_state = 32'h33;
        last_seen = 6'h0;
        {pulses, en_h1, en_h2} = '0;
        srst = 1'b1;
        {key_global_en, elem_colour_valid, lang_sel_en, elem_colour} = '0;
        byte_marker_selector = 8'h0;
        lang_value_flat = {8'h07, 8'h05, 8'h05, 8'h02};
        lang_default_idx = 2'h3;
        page_alarm = 32'h0000_3000;
        for (int i = 0; i < N_PAGES; i++) begin
            page_prio_flat[PRIO_W*i +: PRIO_W] = PRIO_MAX;
            page_roll_flat[ROLL_W*i +: ROLL_W] = (i == 9) ? 5'h02 : 5'h01;
            page_key_mask_flat[KEY_N*i +: KEY_N] = i[3:0];
            page_colour_flat[2*i +: 2] = 2'(i % 3);
        end
        page_prio_flat[PRIO_W*3 +: PRIO_W] = 6'h01;
        page_prio_flat[PRIO_W*5 +: PRIO_W] = 6'h02;
        page_prio_flat[PRIO_W*8 +: PRIO_W] = 6'h01;
        page_prio_flat[PRIO_W*9 +: PRIO_W] = 6'h01;
        repeat (20) @(posedge core_clk);
        #2 srst = 1'b0;
        // Top page held while lower page waits
        key_global_en = 1'b1;
        note(1'b1, 5'h03, 0);
        u_prog.set_en(32'h0000_0008, 1'b1);
        u_prog.set_en(32'h0000_0020, 1'b1);
        drain();
        check(cell_base, 12'h120);
        check(key_active, 4'h3);
        note(1'b1, 5'h05, 0);
        u_prog.set_en(32'h0000_0008, 1'b0);
        drain();
        // Equal priorities rotate by their own rolling times
        note(1'b1, 5'h08, 0);
        note(1'b1, 5'h09, SEC_T);
        note(1'b1, 5'h08, 2 * SEC_T);
        note(1'b1, 5'h09, SEC_T);
        u_prog.set_en(32'h0000_0300, 1'b1);
        drain();
        note(1'b1, 5'h05, 0);
        u_prog.set_en(32'h0000_0300, 1'b0);
        drain();
        // Alarms pre-empt and are held until a rising acknowledge
        note(1'b1, 5'h0c, 0);
        u_prog.set_en(32'h0000_1000, 1'b1);
        u_prog.set_en(32'h0000_2000, 1'b1);
        drain();
        u_prog.set_ack(32'h0000_2000, 1'b1);
        repeat (8) @(posedge core_clk);
        check(pulses, 32'h0);
        note(1'b1, 5'h0d, 0);
        u_prog.set_ack(32'h0000_1000, 1'b1);
        drain();
        check(pulses, 32'h0000_1000);
        pulses = '0;
        repeat (10) @(posedge core_clk);
        check(pulses, 32'h0);
        u_prog.set_ack(32'h0000_2000, 1'b0);
        repeat (3) @(posedge core_clk);
        note(1'b1, 5'h05, 0);
        u_prog.set_ack(32'h0000_2000, 1'b1);
        drain();
        check(pulses, 32'h0000_2000);
        u_prog.set_ack(32'h0000_3000, 1'b0);
        u_prog.set_en(32'h0000_3000, 1'b0);
        check(cell_base, 12'h1e0);
        // Backlight colour, element override and key gating
        for (int k = 0; k < 8; k++) begin
            page_colour_flat[2*5 +: 2] = 2'(k % 4);
            {elem_colour_valid, elem_colour, key_global_en} = 4'(xs());
            repeat (3) @(posedge core_clk);
            #2;
            ec = elem_colour_valid ? elem_colour : 2'(k % 4);
            check(backlight_output, (ec == 2'h3) ? 2'h0 : ec);
            check(key_active, key_global_en ? 4'h5 : 4'h0);
        end
        // Runtime language selection and fallback
        for (int k = 0; k < 12; k++) begin
            lang_sel_en = (k != 0);
            byte_marker_selector = 8'(xs()) & 8'h07;
            exp_lang = lang_default_idx;
            for (int j = LANG_N - 1; j >= 0; j--)
                if (lang_sel_en && lang_value_flat[SEL_W*j +: SEL_W] == byte_marker_selector)
                    exp_lang = 2'(j);
            repeat (3) @(posedge core_clk);
            #2;
            check(lang_index, exp_lang);
        end
        note(1'b0, 5'h00, 0);
        u_prog.set_en(32'h0000_0020, 1'b0);
        drain();
        results();
    end
endmodule
